/* hdl/snv_consts.svh */
/*
 Constants for the two-wire nonvolatile memory target: sizes, select code layout, bit counts.
 Assumes inclusion by bare name from the design files.
*/
`ifndef SNV_CONSTS_SVH
`define SNV_CONSTS_SVH
`define SNV_MEM_DEPTH      16384
`define SNV_ADDR_W         14
// select type code in the upper select bits; the value is arbitrary
`define SNV_TYPE_CODE      4'h5
`define SNV_BITS_PER_BYTE  4'h8
`define SNV_ACK_BIT        4'h8
`endif

/* hdl/snv_pkg.sv */
/*
 Types for the two-wire nonvolatile memory target.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package snv_pkg;
   typedef enum logic [6:0] {
      SNV_IDLE   = 7'h01,
      SNV_SEL    = 7'h02,
      SNV_ADRH   = 7'h04,
      SNV_ADRL   = 7'h08,
      SNV_WDATA  = 7'h10,
      SNV_RDATA  = 7'h20,
      SNV_IGNORE = 7'h40
   } snv_state_e;

   typedef struct packed {
      logic scl;
      logic sda;
   } snv_bus_s;
endpackage

/* hdl/snv_two_wire_slave.sv */
/*
 Two-wire serial target of a 16K x 8 nonvolatile memory, all logic in one module.
 Assumes a bus master supplying scl on i_scl and an external pull-up that resolves sda from o_sda_oe.
*/
`timescale 1ns/1ps
`include "snv_consts.svh"

module snv_two_wire_slave
   import snv_pkg::*;
#(
   parameter int DEPTH  = `SNV_MEM_DEPTH,
   parameter int ADDR_W = `SNV_ADDR_W
)(
   input  wire logic       i_clk,                 // system clock, unused by the link logic
   input  wire logic       i_reset_n,             // synchronous active-low reset
   input  wire logic       i_scl,                 // serial clock from the master, link clock
   input  wire logic       i_sda,                 // resolved serial data line level
   output logic            o_sda_oe,              // high while pulling sda low
   output logic            o_sda,                 // driven level, always low
   input  wire logic [2:0] i_device_select_straps, // strap levels, open reads low
   input  wire logic       i_write_protect,       // high blocks array writes
   output logic            o_busy                 // transaction in progress, system clock domain
);

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   // the array has no reset: its contents are undefined until written
   logic [7:0] mem_q [DEPTH];

   // ----------------------------------------------------------------
   // link lines
   // ----------------------------------------------------------------
   snv_bus_s line_w;

   assign line_w.scl = i_scl;
   assign line_w.sda = i_sda;

   // ----------------------------------------------------------------
   // reset into the link clock domain
   // ----------------------------------------------------------------
   // scl only runs during frames, so reset takes effect after a few
   // rises; a master must clock idle bits while reset is held
   logic [2:0] rst_sync_q;
   logic       rst_scl_n_q;
   wire        rst_agree = rst_sync_q[2] == rst_sync_q[1];

   always_ff @(posedge i_scl)
   begin
      rst_sync_q <= {rst_sync_q[1:0], i_reset_n};
   end

   always_ff @(posedge i_scl)
   begin
      if (rst_agree)
         rst_scl_n_q <= rst_sync_q[2];
   end

   // ----------------------------------------------------------------
   // strap and write-protect pins
   // ----------------------------------------------------------------
   // pins are static in use; the sync costs four scl rises of latency
   // before a change takes hold, far shorter than one select byte
   logic [3:0] pin_s0_q;
   logic [3:0] pin_s1_q;
   logic [3:0] pin_s2_q;
   logic [3:0] pin_q;
   wire  [3:0] pin_raw   = {i_write_protect, i_device_select_straps};
   wire  [3:0] pin_agree = ~(pin_s1_q ^ pin_s2_q);
   wire  [3:0] pin_d     = (pin_q & ~pin_agree) | (pin_s2_q & pin_agree);

   always_ff @(posedge i_scl)
   begin
      pin_s0_q <= pin_raw;
      pin_s1_q <= pin_s0_q;
      pin_s2_q <= pin_s1_q;
   end

   always_ff @(posedge i_scl)
   begin
      if (!rst_scl_n_q)
         pin_q <= 4'h0;
      else
         pin_q <= pin_d;
   end

   wire [2:0] straps_w = pin_q[2:0];
   wire       wp_w     = pin_q[3];

   // ----------------------------------------------------------------
   // start and stop detection
   // ----------------------------------------------------------------
   // sda edges with scl high are the only events off the scl edges;
   // each toggles a flag so the scl-rise logic sees them as levels.
   // reset here is taken on sda edges, so sda must move once each way
   // while reset is held
   logic start_tgl_q;
   logic stop_tgl_q;
   logic start_ack_q;
   logic stop_ack_q;

   always_ff @(negedge i_sda)
   begin
      if (!rst_scl_n_q)
         start_tgl_q <= 1'b0;
      else if (line_w.scl)
         start_tgl_q <= ~start_tgl_q;
   end

   always_ff @(posedge i_sda)
   begin
      if (!rst_scl_n_q)
         stop_tgl_q <= 1'b0;
      else if (line_w.scl)
         stop_tgl_q <= ~stop_tgl_q;
   end

   // a flag differing from its copy taken at the last rise is pending
   always_ff @(posedge i_scl)
   begin
      start_ack_q <= start_tgl_q;
      stop_ack_q  <= stop_tgl_q;
   end

   wire start_pend = start_tgl_q != start_ack_q;
   wire stop_pend  = stop_tgl_q != stop_ack_q;

   // ----------------------------------------------------------------
   // byte decode
   // ----------------------------------------------------------------
   snv_state_e        state_q;
   snv_state_e        state_d;
   snv_state_e        next_after_byte;
   logic [3:0]        bit_q;
   logic [3:0]        bit_d;
   logic              ack_phase_q;
   logic              ack_phase_d;
   logic              rd_sel_ack_q;
   logic              rd_sel_ack_d;
   logic              link_busy_q;
   logic [7:0]        shift_q;
   logic [ADDR_W-1:0] addr_q;
   logic [7:0]        tx_q;
   logic              drive_low_q;

   wire [3:0]        type_code   = `SNV_TYPE_CODE;
   wire [7:0]        rx_byte     = {shift_q[6:0], line_w.sda};
   wire              sel_hit     = (rx_byte[7:4] == type_code) && (rx_byte[3:1] == straps_w);
   wire              sel_read    = rx_byte[0];
   wire              last_bit    = bit_q == 4'h7;
   wire              in_frame    = (state_q != SNV_IDLE) && (state_q != SNV_IGNORE);
   wire              quiet_edge  = rst_scl_n_q && !start_pend && !stop_pend;
   wire              byte_done   = quiet_edge && in_frame && !ack_phase_q && last_bit;
   wire              master_nack = (state_q == SNV_RDATA) && line_w.sda;
   wire [ADDR_W-1:0] addr_inc    = ADDR_W'(addr_q + 1'b1);
   wire              wr_ok       = ~wp_w;
   wire              wr_fire     = byte_done && (state_q == SNV_WDATA) && wr_ok;
   wire              adr_step    = byte_done && ((state_q == SNV_WDATA) || (state_q == SNV_RDATA));
   wire              adrh_load   = byte_done && (state_q == SNV_ADRH);
   wire              adrl_load   = byte_done && (state_q == SNV_ADRL);
   wire              shift_en    = quiet_edge && in_frame && !ack_phase_q;
   wire              rd_sel_done = (state_q == SNV_SEL) && sel_hit && sel_read;
   wire              busy_d      = (state_d != SNV_IDLE) && (state_d != SNV_IGNORE);

   // where a full byte sends the engine
   always_comb
   begin
      next_after_byte = state_q;
      unique case (state_q)
         SNV_SEL:
         begin
            if (!sel_hit)
               next_after_byte = SNV_IGNORE;
            else if (sel_read)
               next_after_byte = SNV_RDATA;
            else
               next_after_byte = SNV_ADRH;
         end
         SNV_ADRH:
            next_after_byte = SNV_ADRL;
         SNV_ADRL:
            next_after_byte = SNV_WDATA;
         SNV_WDATA:
            next_after_byte = SNV_WDATA;
         SNV_RDATA:
            next_after_byte = SNV_RDATA;
         SNV_IDLE:
            next_after_byte = SNV_IDLE;
         SNV_IGNORE:
            next_after_byte = SNV_IGNORE;
      endcase
   end

   // ----------------------------------------------------------------
   // bit engine on scl rise
   // ----------------------------------------------------------------
   always_comb
   begin
      state_d      = state_q;
      bit_d        = bit_q;
      ack_phase_d  = ack_phase_q;
      rd_sel_ack_d = rd_sel_ack_q;
      if (start_pend)
      begin
         // first rise after a start carries the first select bit
         state_d      = SNV_SEL;
         bit_d        = 4'h1;
         ack_phase_d  = 1'b0;
         rd_sel_ack_d = 1'b0;
      end
      else if (stop_pend)
      begin
         state_d      = SNV_IDLE;
         ack_phase_d  = 1'b0;
         rd_sel_ack_d = 1'b0;
      end
      else if (ack_phase_q)
      begin
         ack_phase_d  = 1'b0;
         rd_sel_ack_d = 1'b0;
         bit_d        = 4'h0;
         // high ninth bit after read data is the master's nack
         if (master_nack && !rd_sel_ack_q)
            state_d = SNV_IGNORE;
      end
      else if (in_frame)
      begin
         bit_d = bit_q + 4'h1;
         if (last_bit)
         begin
            ack_phase_d  = 1'b1;
            state_d      = next_after_byte;
            rd_sel_ack_d = rd_sel_done;
         end
      end
   end

   always_ff @(posedge i_scl)
   begin
      if (!rst_scl_n_q)
      begin
         state_q      <= SNV_IDLE;
         bit_q        <= 4'h0;
         ack_phase_q  <= 1'b0;
         rd_sel_ack_q <= 1'b0;
         link_busy_q  <= 1'b0;
      end
      else
      begin
         state_q      <= state_d;
         bit_q        <= bit_d;
         ack_phase_q  <= ack_phase_d;
         rd_sel_ack_q <= rd_sel_ack_d;
         link_busy_q  <= busy_d;
      end
   end

   always_ff @(posedge i_scl)
   begin
      if (!rst_scl_n_q)
         shift_q <= 8'h00;
      else if (start_pend)
         shift_q <= {7'h00, line_w.sda};
      else if (shift_en)
         shift_q <= rx_byte;
   end

   // no reset: the held address is undefined until first set
   always_ff @(posedge i_scl)
   begin
      if (adrh_load)
         addr_q[ADDR_W-1:8] <= rx_byte[ADDR_W-9:0];
      else if (adrl_load)
         addr_q[7:0] <= rx_byte;
      else if (adr_step)
         addr_q <= addr_inc;
   end

   // writes land at the eighth rise, so no busy time follows a stop
   always_ff @(posedge i_scl)
   begin
      if (wr_fire)
         mem_q[addr_q] <= rx_byte;
   end

   // ----------------------------------------------------------------
   // output drive on scl fall
   // ----------------------------------------------------------------
   // read data is fetched in the ack slot, one fall ahead of its first
   // bit; after a read data byte the held address is already n+1
   wire       ack_slot   = ack_phase_q && in_frame;
   wire       slave_acks = ack_slot && ((state_q != SNV_RDATA) || rd_sel_ack_q);
   wire       send_bit   = (state_q == SNV_RDATA) && !ack_phase_q;
   wire [2:0] tx_idx     = 3'h7 - bit_q[2:0];
   wire       tx_bit     = tx_q[tx_idx];

   always_ff @(negedge i_scl)
   begin
      if (ack_slot)
         tx_q <= mem_q[addr_q];
   end

   always_ff @(negedge i_scl)
   begin
      if (!rst_scl_n_q)
         drive_low_q <= 1'b0;
      else if (slave_acks)
         drive_low_q <= 1'b1;
      else if (send_bit)
         drive_low_q <= ~tx_bit;
      else
         drive_low_q <= 1'b0;
   end

   // ----------------------------------------------------------------
   // pins
   // ----------------------------------------------------------------
   // sda is only ever pulled low or released; scl is input only
   assign o_sda_oe = drive_low_q;
   assign o_sda    = 1'b0;

   // ----------------------------------------------------------------
   // status into the system clock domain
   // ----------------------------------------------------------------
   // busy is a registered scl-domain level, so the three-flop sync
   // never sees a decode glitch
   logic [2:0] busy_sync_q;
   wire        busy_agree = busy_sync_q[2] == busy_sync_q[1];

   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
         busy_sync_q <= 3'h0;
      else
         busy_sync_q <= {busy_sync_q[1:0], link_busy_q};
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
         o_busy <= 1'b0;
      else if (busy_agree)
         o_busy <= busy_sync_q[2];
   end

   // ----------------------------------------------------------------
   // notes for integration
   // ----------------------------------------------------------------
   // a stop is acted on at the next scl rise; until then o_busy may
   // stay high with the bus idle. a start right after a stop is taken
   // at once, since the start flag wins over the stop flag.
   // the strap and protect pins take four scl rises to settle, so a
   // change just before a select byte still lands inside that byte.

endmodule

/* test/snv_bus_master.sv */
/* two-wire bus master model that drives scl and pulls sda.
 assumes a pull-up on sda in the bench. */
`timescale 1ns/1ps
module snv_bus_master (
   output logic      o_scl,  // link clock
   output logic      o_pull, // high pulls sda low
   input  wire logic i_sda   // resolved sda
);
   initial
   begin
      o_scl = 1'b1;
      o_pull = 1'b0;
   end
   // sda moves mid-low so it never races an scl edge
   task automatic bit_io(input logic b, output logic r);
      #7.5 o_pull <= ~b;
      #7.5 o_scl <= 1'b1;
      #7.5 r = i_sda;
      #7.5 o_scl <= 1'b0;
   endtask
   task automatic start();
      #7.5 o_pull <= 1'b0;
      #7.5 o_scl <= 1'b1;
      #7.5 o_pull <= 1'b1;
      #7.5 o_scl <= 1'b0;
   endtask
   task automatic stop();
      #7.5 o_pull <= 1'b1;
      #7.5 o_scl <= 1'b1;
      #7.5 o_pull <= 1'b0;
   endtask
   task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], q[i]);
      bit_io(ack_in, ack);
   endtask
endmodule

/* test/snv_two_wire_checker.sv */
/* assertions on the two-wire target ports.
 assumes sda is resolved outside by a pull-up. */
`timescale 1ns/1ps
`include "snv_consts.svh"
module snv_two_wire_checker (
   input wire logic       i_clk,
   input wire logic       i_reset_n,
   input wire logic       i_scl,
   input wire logic       i_sda,
   input wire logic       o_sda_oe,
   input wire logic       o_sda,
   input wire logic [2:0] i_device_select_straps,
   input wire logic       o_busy
);
   logic       st_q = 1'b0;
   logic       seen_q;
   logic       first_q;
   logic       rd_q;
   logic       ok_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q;
   wire        new_w = st_q != seen_q;
   wire        nine_w = cnt_q == 4'h8 && !new_w;
   wire        hit_w = sh_q[7:1] == {`SNV_TYPE_CODE, i_device_select_straps};
   // a start flips a flag; the scl side notices it at the next rise
   always_ff @(negedge i_sda)
      if (i_scl)
         st_q <= ~st_q;
   always_ff @(posedge i_scl)
   begin
      seen_q <= st_q;
      sh_q <= {sh_q[6:0], i_sda};
      cnt_q <= (new_w || cnt_q == 4'h9) ? 4'h1 : cnt_q + 4'h1;
      first_q <= new_w || (first_q && cnt_q != 4'h9);
      ok_q <= (nine_w && first_q) ? hit_w : ok_q;
      rd_q <= (nine_w && first_q) ? sh_q[0] : rd_q;
   end
   sel_ack_a: assert property (@(posedge i_scl) disable iff (!i_reset_n)
      nine_w && first_q && hit_w |-> o_sda_oe) else $error("select not acked");
   sel_nack_a: assert property (@(posedge i_scl) disable iff (!i_reset_n)
      nine_w && first_q && !hit_w |-> !o_sda_oe) else $error("foreign select acked");
   wr_ack_a: assert property (@(posedge i_scl) disable iff (!i_reset_n)
      nine_w && !first_q && ok_q && !rd_q |-> o_sda_oe) else $error("write byte not acked");
   rd_release_a: assert property (@(posedge i_scl) disable iff (!i_reset_n)
      nine_w && !first_q && ok_q && rd_q |-> !o_sda_oe) else $error("ack slot driven");
   nack_quiet_a: assert property (@(posedge i_scl) disable iff (!i_reset_n)
      nine_w && !first_q && rd_q && i_sda |=> !o_sda_oe) else $error("drive after nack");
   sda_low_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_sda == 1'b0) else $error("sda driven high");
   high_hold_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_scl && $past(i_scl) |-> $stable(o_sda_oe)) else $error("sda moved, scl high");
   busy_start_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      $fell(i_sda) && i_scl |-> ##[1:12] o_busy) else $error("start not seen");
   cover property (@(posedge i_scl) nine_w && first_q && !hit_w);
   cover property (@(posedge i_scl) nine_w && !first_q && rd_q && i_sda);
   cover property (@(posedge i_scl) nine_w && !first_q && ok_q && !rd_q);
endmodule
bind snv_two_wire_slave snv_two_wire_checker chk (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_scl(i_scl),
   .i_sda(i_sda), .o_sda_oe(o_sda_oe), .o_sda(o_sda), .i_device_select_straps(i_device_select_straps),
   .o_busy(o_busy));

/* test/snv_two_wire_slave_tb.sv */
/* bench for the two-wire target: wrap, protect and select scenarios.
 assumes the checker is bound from its own file. */
`timescale 1ns/1ps
`include "snv_consts.svh"
module snv_two_wire_slave_tb;
   import snv_pkg::*;
   logic       clk = 1'b0;
   logic       reset_n = 1'b0;
   logic [2:0] straps = 3'h5;
   logic       wp = 1'b0;
   logic [7:0] q;
   logic       a;
   int         fails = 0;
   int         checks_done = 0;
   wire        scl;
   wire        pull;
   wire        oe;
   wire        sda_o;
   wire        busy;
   wire        sda = !(pull || (oe && !sda_o));
   snv_bus_master m (.o_scl(scl), .o_pull(pull), .i_sda(sda));
   snv_two_wire_slave dut (.i_clk(clk), .i_reset_n(reset_n), .i_scl(scl), .i_sda(sda), .o_sda_oe(oe),
      .o_sda(sda_o), .i_device_select_straps(straps), .i_write_protect(wp), .o_busy(busy));
   initial
      forever #5 clk = ~clk;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic sel(input logic [2:0] s, input logic rw);
      m.start();
      m.xfer({`SNV_TYPE_CODE, s, rw}, 1'b1, q, a);
      check({7'h0, a}, {7'h0, s != straps});
   endtask
   task automatic put(input logic [7:0] d);
      m.xfer(d, 1'b1, q, a);
      check({7'h0, a}, 8'h0);
   endtask
   task automatic addr(input logic [13:0] ad);
      sel(straps, 1'b0);
      put({2'h0, ad[13:8]});
      put(ad[7:0]);
   endtask
   task automatic get(input logic mack, input logic [7:0] exp);
      m.xfer(8'hff, mack, q, a);
      check(q, exp);
   endtask
   // write across the top, then random, sequential and current reads
   task automatic t_wrap();
      addr(14'h3fff);
      for (int i = 0; i < 3; i++)
         put(8'ha0 + 8'(i));
      m.stop();
      addr(14'h3fff);
      sel(straps, 1'b1);
      get(1'b0, 8'ha0);
      get(1'b1, 8'ha1);
      m.stop();
      sel(straps, 1'b1);
      get(1'b1, 8'ha2);
      m.stop();
   endtask
   // protected write is acked yet dropped; reads still work
   task automatic t_wp();
      @(posedge clk) wp <= 1'b1;
      #1;
      addr(14'h0000);
      put(8'h3c);
      m.stop();
      addr(14'h0000);
      sel(straps, 1'b1);
      get(1'b1, 8'ha1);
      m.stop();
      @(posedge clk) wp <= 1'b0;
      #1;
   endtask
   // every select code against two strap settings
   task automatic t_sel();
      for (int t = 0; t < 8; t += 7)
      begin
         @(posedge clk) straps <= 3'(t);
         #1;
         for (int s = 0; s < 8; s++)
         begin
            sel(3'(s), 1'b0);
            m.stop();
         end
      end
   endtask
   initial
   begin
      fork
         repeat (8) @(posedge clk);
         begin
            #2 repeat (5) m.bit_io(1'b1, a);
            // move sda both ways so the edge flags take reset
            m.bit_io(1'b0, a);
            m.bit_io(1'b1, a);
         end
      join
      @(posedge clk) reset_n <= 1'b1;
      #1;
      repeat (5) m.bit_io(1'b1, a);
      t_wrap();
      t_wp();
      t_sel();
      complete_run();
   end
   initial
   begin
      #100us;
      fails++;
      complete_run();
   end
endmodule
